/* hdl/cpu_core_pkg.sv */
// shared constants and types for the flag register and operand address logic
package cpu_core_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam int          APB_ADDR_W   = 12;
  localparam logic [11:0] FLAGS_ADDR   = 12'h000;
  localparam logic [11:0] INDEX_ADDR   = 12'h004;
  localparam logic [11:0] STACK_ADDR   = 12'h008;
  localparam logic [11:0] EA_ADDR      = 12'h00C;

  // ----------------------------------------------------------------
  // condition flag field positions and values, reset values and other constants
  // ----------------------------------------------------------------
  localparam int          OVF_BIT      = 7;
  localparam int          HALF_BIT     = 4;
  localparam int          MASK_BIT     = 3;
  localparam int          NEG_BIT      = 2;
  localparam int          ZERO_BIT     = 1;
  localparam int          CARRY_BIT    = 0;
  localparam logic [7:0]  FIXED_ONES   = 8'h60;
  localparam logic [7:0]  MASK_ONLY    = 8'h08;
  localparam logic [7:0]  FLAGS_RESET  = 8'h68;
  localparam logic [15:0] INDEX_RESET  = 16'h0000;
  localparam logic [15:0] STACK_RESET  = 16'h00FF;
  localparam logic [7:0]  PAGE_ZERO_HI = 8'h00;
  localparam logic [15:0] INDEX_STEP   = 16'h0001;
  localparam logic [7:0]  DEC_LOW_FIX  = 8'h06;
  localparam logic [7:0]  DEC_HIGH_FIX = 8'h60;

  // ----------------------------------------------------------------
  // operations, addressing modes and interrupt states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_ADC = 4'h1, OP_SUB = 4'h2, OP_SBC = 4'h3,
    OP_AND = 4'h4, OP_OR = 4'h5, OP_EOR = 4'h6, OP_SHL = 4'h7,
    OP_SHR = 4'h8, OP_LOAD8 = 4'h9, OP_LOAD16 = 4'hA,
    OP_DECIMAL_ADJUST = 4'hB, OP_CLEAR_MASK = 4'hC,
    OP_SET_MASK = 4'hD, OP_BIT_TEST = 4'hE, OP_NONE = 4'hF
  } alu_op_e;

  typedef enum logic [3:0] {
    REGISTER_ONLY_MODE = 4'h0, BRANCH_OFFSET_MODE = 4'h1,
    INLINE_OPERAND_MODE = 4'h2, PAGE_ZERO_MODE = 4'h3,
    FULL_ADDRESS_MODE = 4'h4, PLAIN_INDEX_MODE = 4'h5,
    INDEX_POST_INCREMENT_MODE = 4'h6, INDEX_PLUS_BYTE_MODE = 4'h7,
    INDEX_PLUS_BYTE_POST_INCREMENT_MODE = 4'h8,
    INDEX_PLUS_WORD_MODE = 4'h9, STACK_PLUS_BYTE_MODE = 4'hA,
    STACK_PLUS_WORD_MODE = 4'hB
  } addr_mode_e;

  typedef enum logic [1:0] {
    IRQ_IDLE     = 2'b01,
    IRQ_STACKING = 2'b10
  } irq_state_e;

endpackage

/* hdl/ea_calc.sv */
// combinational operand effective address for every addressing mode
`timescale 1ns/100ps
module ea_calc (
  // mode and bases
  input  wire cpu_core_pkg::addr_mode_e mode,
  input  wire logic [15:0]              index_pair,
  input  wire logic [15:0]              stack_pointer,
  input  wire logic [15:0]              pc_value,
  // instruction bytes after the opcode
  input  wire logic [7:0]               byte_hi,
  input  wire logic [7:0]               byte_lo,
  input  wire logic                     branch_taken,
  // result
  output logic [15:0]                   addr,
  output logic                          mem_access,
  output logic                          post_inc
);

  logic [15:0] word_in;
  logic [15:0] byte_in;
  logic [15:0] rel_in;

  // first byte after the opcode is the high byte
  assign word_in = {byte_hi, byte_lo};
  assign byte_in = {8'h00, byte_hi};
  assign rel_in  = {{8{byte_hi[7]}}, byte_hi};

  // all sums are 16 bits wide, so they wrap
  always_comb begin
    addr       = 16'h0000;
    mem_access = 1'b1;
    post_inc   = 1'b0;
    unique case (mode)
      cpu_core_pkg::REGISTER_ONLY_MODE: mem_access = 1'b0;
      cpu_core_pkg::BRANCH_OFFSET_MODE: begin
        mem_access = 1'b0;
        addr       = branch_taken ? pc_value + rel_in : pc_value;
      end
      cpu_core_pkg::INLINE_OPERAND_MODE: begin
        mem_access = 1'b0;
        addr       = word_in;
      end
      cpu_core_pkg::PAGE_ZERO_MODE: addr = {cpu_core_pkg::PAGE_ZERO_HI, byte_hi};
      cpu_core_pkg::FULL_ADDRESS_MODE: addr = word_in;
      cpu_core_pkg::PLAIN_INDEX_MODE: addr = index_pair;
      cpu_core_pkg::INDEX_POST_INCREMENT_MODE: begin
        addr     = index_pair;
        post_inc = 1'b1;
      end
      cpu_core_pkg::INDEX_PLUS_BYTE_MODE: addr = index_pair + byte_in;
      cpu_core_pkg::INDEX_PLUS_BYTE_POST_INCREMENT_MODE: begin
        addr     = index_pair + byte_in;
        post_inc = 1'b1;
      end
      cpu_core_pkg::INDEX_PLUS_WORD_MODE: addr = index_pair + word_in;
      cpu_core_pkg::STACK_PLUS_BYTE_MODE: addr = stack_pointer + byte_in;
      cpu_core_pkg::STACK_PLUS_WORD_MODE: addr = stack_pointer + word_in;
      default: mem_access = 1'b0;
    endcase
  end

endmodule

/* hdl/cpu_flags_addr.sv */
// condition flag register, interrupt gating and operand address generation
`timescale 1ns/100ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module cpu_flags_addr (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // alu side
  input  wire logic                     alu_valid,
  input  wire cpu_core_pkg::alu_op_e    alu_op,
  input  wire logic [7:0]               alu_a,
  input  wire logic [7:0]               alu_b,
  input  wire logic [15:0]              alu_w,
  output logic [7:0]                    alu_result,
  output logic                          alu_done,
  output logic                          signed_less,
  output logic [7:0]                    flags_out,
  // interrupt gating
  input  wire logic                     irq_request,
  input  wire logic                     instr_boundary,
  input  wire logic                     stack_done,
  output logic                          irq_accept,
  // operand address
  input  wire logic                     ea_req,
  input  wire cpu_core_pkg::addr_mode_e ea_mode,
  input  wire logic [7:0]               ea_byte_hi,
  input  wire logic [7:0]               ea_byte_lo,
  input  wire logic [15:0]              pc_value,
  input  wire logic                     branch_taken,
  input  wire logic                     operand_fetched,
  output logic [15:0]                   ea_addr,
  output logic                          ea_valid,
  output logic                          ea_mem,
  output logic [15:0]                   index_out
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0]              condition_flags;
  logic [15:0]             index_pair;
  logic [15:0]             stack_pointer;
  logic [7:0]              next_flags;
  logic [7:0]              next_result;
  logic [15:0]             ea_addr_c;
  logic                    ea_mem_c;
  logic                    ea_inc_c;
  logic                    post_inc_armed;
  logic                    mask_hold;
  logic                    stack_set;
  logic                    clear_now;
  logic                    wr_fire;
  logic                    rd_fire;
  cpu_core_pkg::irq_state_e irq_state;

  assign wr_fire   = psel & penable & pready & pwrite;
  assign rd_fire   = psel & ~penable & ~pwrite;
  assign stack_set = (irq_state == cpu_core_pkg::IRQ_STACKING) & stack_done;
  assign clear_now = alu_valid & (alu_op == cpu_core_pkg::OP_CLEAR_MASK)
                     & condition_flags[cpu_core_pkg::MASK_BIT];

  // ------------------------------------------------------------
  // alu flag evaluation
  // ------------------------------------------------------------
  always_comb begin
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] corr;
    logic       cin;
    logic       upd_nz;
    sum         = 9'h000;
    low         = 5'h00;
    corr        = 8'h00;
    cin         = 1'b0;
    upd_nz      = 1'b1;
    next_flags  = condition_flags;
    next_result = alu_a;
    unique case (alu_op)
      cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_ADC: begin
        cin = (alu_op == cpu_core_pkg::OP_ADC) & condition_flags[cpu_core_pkg::CARRY_BIT];
        sum = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, cin};
        low = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, cin};
        next_result = sum[7:0];
        next_flags[cpu_core_pkg::HALF_BIT]  = low[4];
        next_flags[cpu_core_pkg::CARRY_BIT] = sum[8];
        next_flags[cpu_core_pkg::OVF_BIT]   = (alu_a[7] == alu_b[7])
                                              & (sum[7] != alu_a[7]);
      end
      cpu_core_pkg::OP_SUB, cpu_core_pkg::OP_SBC: begin
        cin = (alu_op == cpu_core_pkg::OP_SBC) & condition_flags[cpu_core_pkg::CARRY_BIT];
        sum = {1'b0, alu_a} - {1'b0, alu_b} - {8'h00, cin};
        next_result = sum[7:0];
        next_flags[cpu_core_pkg::CARRY_BIT] = sum[8];
        next_flags[cpu_core_pkg::OVF_BIT]   = (alu_a[7] != alu_b[7])
                                              & (sum[7] != alu_a[7]);
      end
      cpu_core_pkg::OP_AND, cpu_core_pkg::OP_OR, cpu_core_pkg::OP_EOR: begin
        next_result = (alu_op == cpu_core_pkg::OP_AND) ? alu_a & alu_b :
                      (alu_op == cpu_core_pkg::OP_OR)  ? alu_a | alu_b : alu_a ^ alu_b;
        next_flags[cpu_core_pkg::OVF_BIT] = 1'b0;
      end
      cpu_core_pkg::OP_SHL: begin
        next_result = {alu_a[6:0], 1'b0};
        next_flags[cpu_core_pkg::CARRY_BIT] = alu_a[7];
        next_flags[cpu_core_pkg::OVF_BIT]   = alu_a[6] ^ alu_a[7];
      end
      cpu_core_pkg::OP_SHR: begin
        next_result = {1'b0, alu_a[7:1]};
        next_flags[cpu_core_pkg::CARRY_BIT] = alu_a[0];
        next_flags[cpu_core_pkg::OVF_BIT]   = alu_a[0];
      end
      cpu_core_pkg::OP_LOAD8: next_flags[cpu_core_pkg::OVF_BIT] = 1'b0;
      cpu_core_pkg::OP_LOAD16: begin
        upd_nz = 1'b0;
        next_flags[cpu_core_pkg::OVF_BIT]  = 1'b0;
        next_flags[cpu_core_pkg::NEG_BIT]  = alu_w[15];
        next_flags[cpu_core_pkg::ZERO_BIT] = (alu_w == 16'h0000);
      end
      cpu_core_pkg::OP_DECIMAL_ADJUST: begin
        // correct the preceding sum using the held half-carry and carry
        if (condition_flags[cpu_core_pkg::HALF_BIT] || alu_a[3:0] > 4'h9) begin
          corr = cpu_core_pkg::DEC_LOW_FIX;
        end
        if (condition_flags[cpu_core_pkg::CARRY_BIT] || alu_a > 8'h99) begin
          corr = corr | cpu_core_pkg::DEC_HIGH_FIX;
          next_flags[cpu_core_pkg::CARRY_BIT] = 1'b1;
        end
        next_result = alu_a + corr;
      end
      cpu_core_pkg::OP_CLEAR_MASK: begin
        upd_nz = 1'b0;
        next_flags[cpu_core_pkg::MASK_BIT] = 1'b0;
      end
      cpu_core_pkg::OP_SET_MASK: begin
        upd_nz = 1'b0;
        next_flags[cpu_core_pkg::MASK_BIT] = 1'b1;
      end
      cpu_core_pkg::OP_BIT_TEST: begin
        // tested bit lands in carry for the branch decision
        upd_nz = 1'b0;
        next_flags[cpu_core_pkg::CARRY_BIT] = alu_a[alu_b[2:0]];
      end
      cpu_core_pkg::OP_NONE: upd_nz = 1'b0;
    endcase
    if (upd_nz) begin
      next_flags[cpu_core_pkg::NEG_BIT]  = next_result[7];
      next_flags[cpu_core_pkg::ZERO_BIT] = (next_result == 8'h00);
    end
  end

  // ------------------------------------------------------------
  // flag register
  // ------------------------------------------------------------
  // an alu update in the same cycle as an apb write wins over the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      condition_flags <= cpu_core_pkg::FLAGS_RESET;
    end else if (alu_valid) begin
      condition_flags <= next_flags | cpu_core_pkg::FIXED_ONES
                         | (stack_set ? cpu_core_pkg::MASK_ONLY : 8'h00);
    end else if (stack_set) begin
      condition_flags <= condition_flags | cpu_core_pkg::MASK_ONLY;
    end else if (wr_fire && paddr == cpu_core_pkg::FLAGS_ADDR) begin
      condition_flags <= pwdata[7:0] | cpu_core_pkg::FIXED_ONES;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alu_result  <= 8'h00;
      alu_done    <= 1'b0;
      signed_less <= 1'b0;
      flags_out   <= cpu_core_pkg::FLAGS_RESET;
    end else begin
      alu_done  <= alu_valid;
      flags_out <= condition_flags;
      if (alu_valid) begin
        alu_result  <= next_result;
        signed_less <= next_flags[cpu_core_pkg::NEG_BIT]
                       ^ next_flags[cpu_core_pkg::OVF_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt gating
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_hold <= 1'b0;
    end else if (clear_now && !instr_boundary) begin
      mask_hold <= 1'b1;
    end else if (instr_boundary) begin
      mask_hold <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_state  <= cpu_core_pkg::IRQ_IDLE;
      irq_accept <= 1'b0;
    end else begin
      irq_accept <= 1'b0;
      unique case (irq_state)
        cpu_core_pkg::IRQ_IDLE: begin
          if (instr_boundary && irq_request && !mask_hold
              && !condition_flags[cpu_core_pkg::MASK_BIT]) begin
            irq_accept <= 1'b1;
            irq_state  <= cpu_core_pkg::IRQ_STACKING;
          end
        end
        cpu_core_pkg::IRQ_STACKING: begin
          if (stack_done) begin
            irq_state <= cpu_core_pkg::IRQ_IDLE;
          end
        end
        default: irq_state <= cpu_core_pkg::IRQ_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // operand address generation
  // ------------------------------------------------------------
  ea_calc u_ea_calc (
    .mode          (ea_mode),
    .index_pair    (index_pair),
    .stack_pointer (stack_pointer),
    .pc_value      (pc_value),
    .byte_hi       (ea_byte_hi),
    .byte_lo       (ea_byte_lo),
    .branch_taken  (branch_taken),
    .addr          (ea_addr_c),
    .mem_access    (ea_mem_c),
    .post_inc      (ea_inc_c)
  );

  // one 16-bit address reaches memory, registers and ports alike
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ea_addr  <= 16'h0000;
      ea_valid <= 1'b0;
      ea_mem   <= 1'b0;
    end else begin
      ea_valid <= ea_req;
      if (ea_req) begin
        ea_addr <= ea_addr_c;
        ea_mem  <= ea_mem_c;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_inc_armed <= 1'b0;
    end else if (ea_req) begin
      post_inc_armed <= ea_inc_c;
    end else if (operand_fetched) begin
      post_inc_armed <= 1'b0;
    end
  end

  // increment only once the operand has been fetched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_pair <= cpu_core_pkg::INDEX_RESET;
    end else if (post_inc_armed && operand_fetched) begin
      index_pair <= index_pair + cpu_core_pkg::INDEX_STEP;
    end else if (wr_fire && paddr == cpu_core_pkg::INDEX_ADDR) begin
      index_pair <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_pointer <= cpu_core_pkg::STACK_RESET;
    end else if (wr_fire && paddr == cpu_core_pkg::STACK_ADDR) begin
      stack_pointer <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_out <= cpu_core_pkg::INDEX_RESET;
    end else begin
      index_out <= index_pair;
    end
  end

  // ------------------------------------------------------------
  // apb slave: one wait-free access cycle, error on unmapped offsets
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        unique case (paddr)
          cpu_core_pkg::FLAGS_ADDR: begin
            if (rd_fire) prdata <= {24'h000000, condition_flags};
          end
          cpu_core_pkg::INDEX_ADDR: begin
            if (rd_fire) prdata <= {16'h0000, index_pair};
          end
          cpu_core_pkg::STACK_ADDR: begin
            if (rd_fire) prdata <= {16'h0000, stack_pointer};
          end
          cpu_core_pkg::EA_ADDR: begin
            if (rd_fire) prdata <= {16'h0000, ea_addr};
          end
          default: begin
            pslverr <= 1'b1;
            prdata  <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_clear_then_boundary;
    clear_now && !instr_boundary ##1 instr_boundary;
  endsequence

  sequence s_stack_end;
    irq_state == cpu_core_pkg::IRQ_STACKING && stack_done;
  endsequence

  property p_fixed_ones;
    condition_flags[6:5] == 2'b11 && flags_out[6:5] == 2'b11;
  endproperty
  a_fixed_ones: assert property (p_fixed_ones) else $error("fixed flag bits not one");

  property p_add_overflow;
    alu_valid && alu_op == cpu_core_pkg::OP_ADD |=>
      condition_flags[7] == ($past(alu_a[7]) == $past(alu_b[7])
                             && alu_result[7] != $past(alu_a[7]));
  endproperty
  a_add_overflow: assert property (p_add_overflow) else $error("overflow flag wrong");

  property p_half_carry;
    alu_valid && alu_op == cpu_core_pkg::OP_ADD |=>
      condition_flags[4] == (({1'b0, $past(alu_a[3:0])} + {1'b0, $past(alu_b[3:0])})
                             >= 5'h10);
  endproperty
  a_half_carry: assert property (p_half_carry) else $error("half-carry flag wrong");

  property p_mask_blocks;
    instr_boundary && condition_flags[3] |=> !irq_accept;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked interrupt taken");

  property p_mask_after_stack;
    s_stack_end |=> condition_flags[3] && irq_state == cpu_core_pkg::IRQ_IDLE;
  endproperty
  a_mask_after_stack: assert property (p_mask_after_stack) else $error("mask not set");

  property p_boundary_after_clear;
    s_clear_then_boundary |=> !irq_accept;
  endproperty
  a_boundary_after_clear: assert property (p_boundary_after_clear) else $error("early irq");

  property p_load_sign_zero;
    alu_valid && alu_op == cpu_core_pkg::OP_LOAD8 |=>
      condition_flags[2] == $past(alu_a[7]) && condition_flags[1] == ($past(alu_a) == 8'h00);
  endproperty
  a_load_sign_zero: assert property (p_load_sign_zero) else $error("load flags wrong");

  property p_register_only;
    ea_req && ea_mode == cpu_core_pkg::REGISTER_ONLY_MODE |=> ea_valid && !ea_mem;
  endproperty
  a_register_only: assert property (p_register_only) else $error("register mode accessed");

  property p_branch_target;
    ea_req && ea_mode == cpu_core_pkg::BRANCH_OFFSET_MODE && branch_taken |=>
      ea_addr == $past(pc_value) + {{8{$past(ea_byte_hi[7])}}, $past(ea_byte_hi)};
  endproperty
  a_branch_target: assert property (p_branch_target) else $error("branch target wrong");

  property p_page_zero;
    ea_req && ea_mode == cpu_core_pkg::PAGE_ZERO_MODE |=>
      ea_addr == {8'h00, $past(ea_byte_hi)} && ea_mem;
  endproperty
  a_page_zero: assert property (p_page_zero) else $error("page zero address wrong");

  property p_post_increment;
    post_inc_armed && operand_fetched && !ea_req |=>
      index_pair == $past(index_pair) + 16'h0001 && !post_inc_armed;
  endproperty
  a_post_increment: assert property (p_post_increment) else $error("index not stepped");

endmodule

/* testbench/addr_space_model.sv */
// partner model: flat 16-bit operand space that counts memory accesses
`timescale 1ns/100ps
module addr_space_model (
  // operand address from the block
  input  wire logic        pclk,
  input  wire logic        ea_valid,
  input  wire logic        ea_mem,
  input  wire logic [15:0] ea_addr,
  // observed traffic
  output int               accesses,
  output logic [15:0]      last_addr
);
  initial accesses = 0;
  // one flat space, so any 16-bit address is a legal target
  always @(posedge pclk) if (ea_valid === 1'b1 && ea_mem === 1'b1) begin
    accesses  <= accesses + 1;
    last_addr <= ea_addr;
  end
endmodule

/* testbench/tb.sv */
// testbench: apb, alu, interrupt and operand address sequences
`timescale 1ns/100ps
module tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic        alu_valid = 0, irq_request = 0, instr_boundary = 0, stack_done = 0;
  logic        ea_req = 0, operand_fetched = 0, branch_taken = 1;
  logic        pready, pslverr, alu_done, signed_less, irq_accept, ea_valid, ea_mem;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0]  alu_a = 0, alu_b = 0, ea_byte_hi = 0, ea_byte_lo = 0, alu_result, flags_out;
  logic [15:0] alu_w = 0, pc_value = 16'h1000, ea_addr, index_out, last_addr;
  int          mismatches = 0, compares = 0, accesses;
  cpu_core_pkg::alu_op_e    alu_op = cpu_core_pkg::OP_NONE;
  cpu_core_pkg::addr_mode_e ea_mode = cpu_core_pkg::REGISTER_ONLY_MODE;
  cpu_flags_addr uut (.*);
  addr_space_model partner (.*);
  always #4 pclk = ~pclk;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic ck(input string nm, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic alu(input cpu_core_pkg::alu_op_e op, input logic [7:0] a, b, x, f);
    alu_valid <= 1;
    alu_op    <= op;
    alu_a     <= a;
    alu_b     <= b;
    @(posedge pclk);
    alu_valid <= 0;
    @(posedge pclk);
    ck("alu_done", 1, alu_done);
    ck("alu_result", x, alu_result);
    apb(0, cpu_core_pkg::FLAGS_ADDR, 0);
    if (f !== 8'h00) ck("flags", f, rd);
    if (f !== 8'h00) ck("flags_out", f, flags_out);
  endtask
  task automatic ea(input cpu_core_pkg::addr_mode_e m, input logic [7:0] h, l,
                    input logic [15:0] x, input int mem);
    ea_req     <= 1;
    ea_mode    <= m;
    ea_byte_hi <= h;
    ea_byte_lo <= l;
    @(posedge pclk);
    ea_req <= 0;
    @(posedge pclk);
    ck("ea_valid", 1, ea_valid);
    if (!$isunknown(x)) ck("ea_addr", x, ea_addr);
    if (mem < 2) ck("ea_mem", mem, ea_mem);
  endtask
  task automatic irq(input logic x);
    irq_request    <= 1;
    instr_boundary <= 1;
    @(posedge pclk);
    instr_boundary <= 0;
    irq_request    <= 0;
    @(posedge pclk);
    ck("irq_accept", x, irq_accept);
  endtask
  task automatic fetch(input logic [15:0] x);
    operand_fetched <= 1;
    @(posedge pclk);
    operand_fetched <= 0;
    repeat (2) @(posedge pclk);
    ck("index_out", x, index_out);
  endtask
  task automatic stop_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    alu(cpu_core_pkg::OP_NONE, 0, 0, 0, 8'h68);
    irq(0);
    apb(1, 12'h010, 32'h5);
    ck("unmapped", 1, err);
    apb(1, cpu_core_pkg::FLAGS_ADDR, 0);
    alu(cpu_core_pkg::OP_NONE, 0, 0, 0, 8'h60);
    alu(cpu_core_pkg::OP_ADD, 8'h08, 8'h08, 8'h10, 8'h70);
    alu(cpu_core_pkg::OP_DECIMAL_ADJUST, 8'h10, 0, 8'h16, 8'h70);
    alu(cpu_core_pkg::OP_ADD, 8'h80, 8'h80, 8'h00, 8'hE3);
    ck("signed_less", 1, signed_less);
    alu(cpu_core_pkg::OP_ADD, 8'h7F, 8'h01, 8'h80, 8'hF4);
    alu(cpu_core_pkg::OP_ADD, 8'h15, 8'h27, 8'h3C, 8'h60);
    alu(cpu_core_pkg::OP_DECIMAL_ADJUST, 8'h3C, 0, 8'h42, 8'h60);
    alu(cpu_core_pkg::OP_SUB, 8'h10, 8'h20, 8'hF0, 8'h65);
    ck("signed_less", 1, signed_less);
    alu(cpu_core_pkg::OP_LOAD8, 8'h00, 0, 8'h00, 8'h63);
    alu_w <= 16'h8000;
    alu(cpu_core_pkg::OP_LOAD16, 0, 0, 0, 8'h65);
    alu(cpu_core_pkg::OP_BIT_TEST, 8'h04, 8'h00, 8'h04, 8'h64);
    irq(1);
    stack_done <= 1;
    @(posedge pclk);
    stack_done <= 0;
    apb(0, cpu_core_pkg::FLAGS_ADDR, 0);
    ck("mask", 1, rd[3]);
    alu_valid <= 1;
    alu_op    <= cpu_core_pkg::OP_CLEAR_MASK;
    @(posedge pclk);
    alu_valid <= 0;
    irq(0);
    irq(1);
    stack_done <= 1;
    @(posedge pclk);
    stack_done <= 0;
    apb(1, cpu_core_pkg::INDEX_ADDR, 32'h1234);
    apb(1, cpu_core_pkg::STACK_ADDR, 32'h0200);
    ea(cpu_core_pkg::PAGE_ZERO_MODE, 8'h42, 8'h99, 16'h0042, 1);
    ea(cpu_core_pkg::FULL_ADDRESS_MODE, 8'hAB, 8'hCD, 16'hABCD, 1);
    ea(cpu_core_pkg::INLINE_OPERAND_MODE, 8'hAB, 8'hCD, 16'hABCD, 0);
    ea(cpu_core_pkg::REGISTER_ONLY_MODE, 0, 0, 16'hx, 0);
    ck("accesses", 2, accesses);
    ck("last_addr", 16'hABCD, last_addr);
    ea(cpu_core_pkg::BRANCH_OFFSET_MODE, 8'hFE, 0, 16'h0FFE, 0);
    branch_taken <= 0;
    ea(cpu_core_pkg::BRANCH_OFFSET_MODE, 8'hFE, 0, 16'h1000, 0);
    ea(cpu_core_pkg::PLAIN_INDEX_MODE, 0, 0, 16'h1234, 1);
    ea(cpu_core_pkg::INDEX_PLUS_BYTE_MODE, 8'hF0, 0, 16'h1324, 1);
    ea(cpu_core_pkg::INDEX_PLUS_WORD_MODE, 8'hFF, 8'hFF, 16'h1233, 1);
    ea(cpu_core_pkg::STACK_PLUS_BYTE_MODE, 8'h80, 0, 16'h0280, 1);
    ea(cpu_core_pkg::STACK_PLUS_WORD_MODE, 8'h01, 0, 16'h0300, 1);
    ea(cpu_core_pkg::INDEX_POST_INCREMENT_MODE, 0, 0, 16'h1234, 1);
    fetch(16'h1235);
    ea(cpu_core_pkg::INDEX_PLUS_BYTE_POST_INCREMENT_MODE, 8'h10, 0, 16'h1245, 1);
    fetch(16'h1236);
    apb(1, cpu_core_pkg::INDEX_ADDR, 32'hFFFF);
    ea(cpu_core_pkg::INDEX_POST_INCREMENT_MODE, 0, 0, 16'hFFFF, 1);
    fetch(16'h0000);
    stop_test();
  end
  // a hang must still end in a verdict
  initial begin
    #20000;
    mismatches++;
    stop_test();
  end
endmodule
